// *** core/tct_pkg.sv ***
package tct_pkg;
	// ----------------------------------------
	// Sizes and reset values
	// ----------------------------------------
	localparam int TCT_NUM_TIMERS = 3;
	localparam int TCT_CNT_W = 32;
	localparam int TCT_PSC_W = 16;
	localparam logic [31:0] TCT_PERIOD_RST = 32'hFFFFFFFF;
	localparam logic [15:0] TCT_PSC_RST = 16'h0000;
	localparam int TCT_CLK_SEL_W = 3;

	// Clock source choices for timer 2
	typedef enum logic [2:0] {
		TCT_SRC_SYSTEM_CLOCK = 3'h0,
		TCT_SRC_INTERNAL_OSC_ONE = 3'h1,
		TCT_SRC_INTERNAL_OSC_TWO = 3'h3,
		TCT_SRC_CRYSTAL_INPUT = 3'h2,
		TCT_SRC_AUX_PLL_CLOCK = 3'h6
	} tct_src_t;
	localparam tct_src_t TCT_SRC_RST = TCT_SRC_SYSTEM_CLOCK;
endpackage

// *** core/tct_channel.sv ***
`timescale 1ns/1ps
// One countdown timer: prescaler plus 32-bit down counter with auto reload
module tct_channel
	import tct_pkg::*;
#(
	parameter int CNT_W = TCT_CNT_W,
	parameter int PSC_W = TCT_PSC_W
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic tick_en,
	input wire logic [CNT_W-1:0] period,
	input wire logic [PSC_W-1:0] prescale,
	input wire logic reload,
	output logic [CNT_W-1:0] count_r,
	output logic irq_r
);
	logic [PSC_W-1:0] psc_r;
	logic dec_tick;

	// Refuse widths the counter compare cannot serve, at elaboration
	if (CNT_W < 2 || PSC_W < 1) begin : g_bad_width
		$error("tct_channel: widths too small");
	end

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	// Divide by prescale+1 so that zero means no division
	assign dec_tick = tick_en && (psc_r == '0);

	always_ff @(posedge mclk) begin
		if (!reset_n || reload) begin
			psc_r <= prescale;
		end else if (tick_en) begin
			if (psc_r == '0) begin
				psc_r <= prescale;
			end else begin
				psc_r <= psc_r - 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Main counter
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			count_r <= CNT_W'(TCT_PERIOD_RST);
		end else if (reload) begin
			count_r <= period;
		end else if (dec_tick) begin
			if (count_r == '0) begin
				count_r <= period;
			end else begin
				count_r <= count_r - 1'b1;
			end
		end
	end

	// One-cycle request as the count steps onto zero
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= dec_tick && !reload && (count_r == {{(CNT_W-1){1'b0}}, 1'b1});
		end
	end
endmodule

// *** core/tct_timers.sv ***
`timescale 1ns/1ps
// Behaviour
// - Three identical timers, each 32-bit down counter with software period.
// - Each timer has a 16-bit prescale setting dividing its clock.
// - Counter decrements once per prescaled clock interval.
// - Interrupt request raised when the counter reaches zero.
// - At zero the counter reloads from period and keeps counting.
// - Timer 0 request goes to the peripheral interrupt expander.
// - Timer 1 request drives CPU interrupt line thirteen.
// - Timer 2 request drives CPU interrupt line fourteen.
// - Timer 2 clock from five sources, system clock by default.
module tct_timers
	import tct_pkg::*;
#(
	parameter int CNT_W = TCT_CNT_W,
	parameter int PSC_W = TCT_PSC_W
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [CNT_W-1:0] period0,
	input wire logic [CNT_W-1:0] period1,
	input wire logic [CNT_W-1:0] period2,
	input wire logic [PSC_W-1:0] prescale0,
	input wire logic [PSC_W-1:0] prescale1,
	input wire logic [PSC_W-1:0] prescale2,
	input wire logic [2:0] reload,
	input wire logic [TCT_CLK_SEL_W-1:0] timer2_clk_sel,
	input wire logic internal_oscillator_one,
	input wire logic internal_oscillator_two,
	input wire logic crystal_input,
	input wire logic auxiliary_pll_clock,
	output logic [CNT_W-1:0] count0,
	output logic [CNT_W-1:0] count1,
	output logic [CNT_W-1:0] count2,
	output logic peripheral_interrupt_expander,
	output logic cpu_irq_line_thirteen,
	output logic cpu_irq_line_fourteen
);
	logic [CNT_W-1:0] period_a [TCT_NUM_TIMERS];
	logic [PSC_W-1:0] psc_a [TCT_NUM_TIMERS];
	logic [CNT_W-1:0] count_a [TCT_NUM_TIMERS];
	logic [TCT_NUM_TIMERS-1:0] irq_a;
	logic [TCT_NUM_TIMERS-1:0] tick_en;
	tct_src_t src_r;
	logic src_lvl;
	logic src_d_r;

	// Refuse widths the routing and checks cannot serve, at elaboration
	if (CNT_W != TCT_CNT_W || PSC_W > TCT_PSC_W || PSC_W < 1) begin : g_bad_width
		$error("tct_timers: unsupported widths");
	end

	assign period_a[0] = period0;
	assign period_a[1] = period1;
	assign period_a[2] = period2;
	assign psc_a[0] = prescale0;
	assign psc_a[1] = prescale1;
	assign psc_a[2] = prescale2;

	// ----------------------------------------
	// Timer 2 clock source
	// ----------------------------------------
	// Illegal select codes keep the previous source
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			src_r <= TCT_SRC_RST;
		end else begin
			unique case (timer2_clk_sel)
				TCT_SRC_SYSTEM_CLOCK,
				TCT_SRC_INTERNAL_OSC_ONE,
				TCT_SRC_INTERNAL_OSC_TWO,
				TCT_SRC_CRYSTAL_INPUT,
				TCT_SRC_AUX_PLL_CLOCK: src_r <= tct_src_t'(timer2_clk_sel);
				default: src_r <= src_r;
			endcase
		end
	end

	// Slow sources are sampled as levels; each rising edge is one tick.
	// Limitation: a source must stay below half of mclk.
	always_comb begin
		src_lvl = 1'b0;
		unique case (src_r)
			TCT_SRC_SYSTEM_CLOCK: src_lvl = 1'b0;
			TCT_SRC_INTERNAL_OSC_ONE: src_lvl = internal_oscillator_one;
			TCT_SRC_INTERNAL_OSC_TWO: src_lvl = internal_oscillator_two;
			TCT_SRC_CRYSTAL_INPUT: src_lvl = crystal_input;
			TCT_SRC_AUX_PLL_CLOCK: src_lvl = auxiliary_pll_clock;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			src_d_r <= 1'b0;
		end else begin
			src_d_r <= src_lvl;
		end
	end

	// Timers 0 and 1 tick on every CPU clock
	assign tick_en[0] = 1'b1;
	assign tick_en[1] = 1'b1;
	assign tick_en[2] = (src_r == TCT_SRC_SYSTEM_CLOCK) ? 1'b1 : (src_lvl && !src_d_r);

	// ----------------------------------------
	// Timer channels
	// ----------------------------------------
	for (genvar i = 0; i < TCT_NUM_TIMERS; i++) begin : g_tmr
		tct_channel #(
			.CNT_W(CNT_W),
			.PSC_W(PSC_W)
		) u_chan (
			.mclk(mclk),
			.reset_n(reset_n),
			.tick_en(tick_en[i]),
			.period(period_a[i]),
			.prescale(psc_a[i]),
			.reload(reload[i]),
			.count_r(count_a[i]),
			.irq_r(irq_a[i])
		);
	end

	// ----------------------------------------
	// Output routing
	// ----------------------------------------
	// Extra flop keeps every output straight from a register
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			peripheral_interrupt_expander <= 1'b0;
			cpu_irq_line_thirteen <= 1'b0;
			cpu_irq_line_fourteen <= 1'b0;
			count0 <= CNT_W'(TCT_PERIOD_RST);
			count1 <= CNT_W'(TCT_PERIOD_RST);
			count2 <= CNT_W'(TCT_PERIOD_RST);
		end else begin
			peripheral_interrupt_expander <= irq_a[0];
			cpu_irq_line_thirteen <= irq_a[1];
			cpu_irq_line_fourteen <= irq_a[2];
			count0 <= count_a[0];
			count1 <= count_a[1];
			count2 <= count_a[2];
		end
	end
endmodule

// *** verification/tct_timers_chk.sv ***
`timescale 1ns/1ps
// Port checks; period held steady by the bench
module tct_timers_chk
	import tct_pkg::*;
#(
	parameter int CNT_W = TCT_CNT_W,
	parameter int PSC_W = TCT_PSC_W
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [CNT_W-1:0] period0,
	input wire logic [CNT_W-1:0] period1,
	input wire logic [2:0] reload,
	input wire logic [CNT_W-1:0] count0,
	input wire logic [CNT_W-1:0] count1,
	input wire logic [CNT_W-1:0] count2,
	input wire logic peripheral_interrupt_expander,
	input wire logic cpu_irq_line_thirteen,
	input wire logic cpu_irq_line_fourteen
);
default clocking @(posedge mclk); endclocking
default disable iff (!reset_n);
AST_LOAD0: assert property (reload[0] |-> ##2 count0 == $past(period0, 2))
	else $error("load");
AST_ZERO0: assert property (peripheral_interrupt_expander |-> count0 == 0)
	else $error("irq0");
AST_ZERO1: assert property (cpu_irq_line_thirteen |-> count1 == 0)
	else $error("irq1");
AST_ZERO2: assert property (cpu_irq_line_fourteen |-> count2 == 0)
	else $error("irq2");
AST_HIT0: assert property ($past(count0) == 1 && count0 == 0 |-> peripheral_interrupt_expander)
	else $error("hit");
AST_PULSE1: assert property (cpu_irq_line_thirteen |=> !cpu_irq_line_thirteen)
	else $error("pulse");
AST_WRAP1: assert property ($past(count1) == 0 && count1 != 0 |-> count1 == $past(period1))
	else $error("wrap");
AST_STEP1: assert property ($past(count1) != 0 && $changed(count1) |-> count1 == $past(count1) - 1 ||
	count1 == $past(period1, 2)) else $error("step");
endmodule
bind tct_timers tct_timers_chk #(.CNT_W(CNT_W), .PSC_W(PSC_W)) tct_timers_chk_inst (.*);

// *** verification/tct_irq_sink.sv ***
`timescale 1ns/1ps
// Interrupt inputs: flag each request, keep edges since the last one
module tct_irq_sink (
	input wire logic mclk,
	input wire logic [2:0] line,
	output logic [2:0] hit,
	output logic [2:0][31:0] gap
);
logic [2:0][31:0] run_r;
always_ff @(posedge mclk) begin
	hit <= line;
	for (int i = 0; i < 3; i++) begin
		run_r[i] <= line[i] ? 32'h1 : run_r[i] + 32'h1;
		if (line[i]) gap[i] <= run_r[i];
	end
end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin bad_count++; \
	$display("mismatch %s exp %0d got %0d", n, e, s); end end
module tb_top;
import tct_pkg::*;
logic mclk = 0, reset_n = 0;
logic [31:0] per[3] = '{default: 32'h5}, cnt[3];
logic [15:0] psc[3] = '{default: 16'h0};
logic [2:0] reload = 0, irq, hit, sel = 3'h0;
logic [2:0][31:0] gap;
logic [5:0] cyc = 0;
logic [31:0] seed = 75574;
int bad_count, check_count, tick, q[3][$];
tct_src_t src[5] = '{TCT_SRC_SYSTEM_CLOCK, TCT_SRC_INTERNAL_OSC_ONE, TCT_SRC_INTERNAL_OSC_TWO,
	TCT_SRC_CRYSTAL_INPUT, TCT_SRC_AUX_PLL_CLOCK};
tct_timers tct_timers_inst (.mclk(mclk), .reset_n(reset_n), .period0(per[0]), .period1(per[1]),
	.period2(per[2]), .prescale0(psc[0]), .prescale1(psc[1]), .prescale2(psc[2]), .reload(reload),
	.timer2_clk_sel(sel), .internal_oscillator_one(cyc[1]), .internal_oscillator_two(cyc[2]),
	.crystal_input(cyc[3]), .auxiliary_pll_clock(cyc[4]), .count0(cnt[0]), .count1(cnt[1]),
	.count2(cnt[2]), .peripheral_interrupt_expander(irq[0]), .cpu_irq_line_thirteen(irq[1]),
	.cpu_irq_line_fourteen(irq[2]));
tct_irq_sink tct_irq_sink_inst (.mclk(mclk), .line(irq), .hit(hit), .gap(gap));
always #4 mclk = ~mclk;
// Slow sources: rising edge every 4, 8, 16, 32 cycles
always @(negedge mclk) cyc <= cyc + 1;
function automatic logic [31:0] rnd();
	seed ^= seed << 13;
	seed ^= seed >> 17;
	seed ^= seed << 5;
	return seed;
endfunction
task automatic conclude();
	$display("checks %0d mismatches %0d", check_count, bad_count);
	if (bad_count == 0 && check_count > 0) $display("TB: PASS");
	else $display("TB: FAIL");
	$finish;
endtask
// First request after a reload is skipped: its delay hides prescaler phase
task automatic run(int t, int m);
	int g;
	per[t] = 32'h1 + (rnd() & 32'h7);
	psc[t] = 16'(rnd() & 32'h3);
	g = m * (per[t] + 1) * (psc[t] + 1);
	reload[t] = 1;
	@(negedge mclk) reload[t] = 0;
	while (!hit[t]) @(negedge mclk);
	@(negedge mclk) q[t].push_back(g);
	q[t].push_back(g);
	while (q[t].size()) @(negedge mclk);
	$display("timer %0d gap %0d done", t, g);
endtask
// Each request that finds spacings queued pops the oldest expected one
always @(negedge mclk) begin
	int e;
	for (int t = 0; t < 3; t++) if (hit[t] && q[t].size()) begin
		e = q[t].pop_front();
		`CHK("gap", e, gap[t])
	end
end
always @(posedge mclk) begin
	tick++;
	if (tick > 40000) begin
		bad_count++;
		conclude();
	end
end
initial begin
	repeat (5) @(negedge mclk);
	`CHK("rst", TCT_PERIOD_RST, cnt[1])
	reset_n = 1;
	run(0, 1);
	run(1, 1);
	for (int k = 0; k < 5; k++) begin
		sel = src[k];
		run(2, k ? 2 << k : 1);
	end
	conclude();
end
endmodule
